// File: verilog/neutral_current_mismatch_detect.sv
// neutral current mismatch detector with its host-visible registers
// assumes current samples come from on-chip logic on core_clk and hold steady
// around each sample tick; host register port is single-cycle on core_clk
`timescale 1ns/1ps

module neutral_current_mismatch_detect #(
	parameter int SAMPLE_CYCLES = nc_mismatch_pkg::SAMPLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic signed [nc_mismatch_pkg::SAMPLE_W-1:0] phase_a_current_sample,
	input wire logic signed [nc_mismatch_pkg::SAMPLE_W-1:0] phase_b_current_sample,
	input wire logic signed [nc_mismatch_pkg::SAMPLE_W-1:0] phase_c_current_sample,
	input wire logic signed [nc_mismatch_pkg::SAMPLE_W-1:0] neutral_current_sample,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [nc_mismatch_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [nc_mismatch_pkg::WORD_W-1:0] reg_wdata,
	output logic [nc_mismatch_pkg::WORD_W-1:0] reg_rdata,
	output logic reg_rdata_valid,
	output logic second_interrupt_pin_n
);
	localparam int SUM_W = nc_mismatch_pkg::SUM_W;
	localparam int SAMPLE_W = nc_mismatch_pkg::SAMPLE_W;
	localparam int WORD_W = nc_mismatch_pkg::WORD_W;
	localparam int DIV_W = nc_mismatch_pkg::DIV_W;
	localparam int DR_BIT = nc_mismatch_pkg::DATA_READY_BIT;
	localparam int MM_BIT = nc_mismatch_pkg::MISMATCH_BIT;
	localparam int SEL_BIT = nc_mismatch_pkg::NEUTRAL_SEL_BIT;

	logic [DIV_W-1:0] div_cnt;
	logic sample_tick;
	logic signed [SUM_W-1:0] phase_current_sum;
	logic signed [SUM_W-1:0] neutral_hold;
	logic cmp_pending;
	logic data_ready_flag;
	logic mismatch_flag;
	logic [WORD_W-1:0] second_interrupt_mask;
	logic neutral_input_select;
	logic signed [SAMPLE_W-1:0] mismatch_threshold;
	logic [nc_mismatch_pkg::RMS_W-1:0] neutral_rms_result;
	logic [SUM_W-1:0] abs_sum;
	logic [SUM_W-1:0] abs_neutral;
	logic signed [SUM_W-1:0] mag_diff;
	logic signed [SUM_W-1:0] abs_diff;
	logic signed [SUM_W-1:0] threshold_ext;
	logic exceed;
	logic wr_second_status_register;
	logic wr_first_status_register;
	logic [WORD_W-1:0] first_status_register_word;
	logic [WORD_W-1:0] second_status_register_word;
	logic [WORD_W-1:0] next_rdata;

	// ==========================================================
	// 8 kHz sample enable
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= '0;
			sample_tick <= 1'b0;
		end else if (div_cnt == DIV_W'(SAMPLE_CYCLES - 1)) begin
			div_cnt <= '0;
			sample_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			sample_tick <= 1'b0;
		end
	end

	// ==========================================================
	// phase sum and neutral capture
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			phase_current_sum <= '0;
			neutral_hold <= '0;
			cmp_pending <= 1'b0;
		end else begin
			cmp_pending <= sample_tick;
			if (sample_tick) begin
				phase_current_sum <= SUM_W'(phase_a_current_sample)
					+ SUM_W'(phase_b_current_sample)
					+ SUM_W'(phase_c_current_sample);
				neutral_hold <= SUM_W'(neutral_current_sample);
			end
		end
	end

	// ==========================================================
	// mismatch comparison
	always_comb begin
		// sum of three 24-bit samples never reaches -2^27, so negation is safe
		abs_sum = phase_current_sum[SUM_W-1] ? SUM_W'(-phase_current_sum) :
			SUM_W'(phase_current_sum);
		abs_neutral = neutral_hold[SUM_W-1] ? SUM_W'(-neutral_hold) :
			SUM_W'(neutral_hold);
		mag_diff = $signed(abs_sum) - $signed(abs_neutral);
		abs_diff = mag_diff[SUM_W-1] ? -mag_diff : mag_diff;
		// threshold is in adc output units, same as the samples
		threshold_ext = SUM_W'(mismatch_threshold);
		exceed = (threshold_ext <= 0) || (abs_diff > threshold_ext);
	end

	assign wr_first_status_register = reg_wr_en && (reg_addr == nc_mismatch_pkg::ADDR_FIRST_STATUS);
	assign wr_second_status_register = reg_wr_en && (reg_addr == nc_mismatch_pkg::ADDR_SECOND_STATUS);

	// ==========================================================
	// status flags, set wins over a same-cycle clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			data_ready_flag <= 1'b0;
		end else if (cmp_pending) begin
			data_ready_flag <= 1'b1;
		end else if (wr_first_status_register && reg_wdata[DR_BIT]) begin
			data_ready_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mismatch_flag <= 1'b0;
		end else if (cmp_pending && exceed) begin
			mismatch_flag <= 1'b1;
		end else if (wr_second_status_register && reg_wdata[MM_BIT]) begin
			mismatch_flag <= 1'b0;
		end
	end

	// ==========================================================
	// writable registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			second_interrupt_mask <= nc_mismatch_pkg::MASK_RESET;
			neutral_input_select <= 1'b0;
			mismatch_threshold <= nc_mismatch_pkg::THRESHOLD_RESET;
		end else if (reg_wr_en) begin
			case (reg_addr)
				nc_mismatch_pkg::ADDR_SECOND_MASK: second_interrupt_mask <= reg_wdata;
				nc_mismatch_pkg::ADDR_CONFIG: neutral_input_select <= reg_wdata[SEL_BIT];
				// only the low 24 bits hold state; upper sign copies are implied
				nc_mismatch_pkg::ADDR_THRESHOLD: mismatch_threshold <= reg_wdata[SAMPLE_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// interrupt pin
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			second_interrupt_pin_n <= 1'b1;
		end else begin
			second_interrupt_pin_n <= ~|(second_status_register_word & second_interrupt_mask);
		end
	end

	// ==========================================================
	// neutral rms from the phase sum
	sum_rms #(
		.SUM_W(SUM_W),
		.SHIFT(nc_mismatch_pkg::RMS_LPF_SHIFT)
	) u_rms (
		.core_clk(core_clk),
		.nrst(nrst),
		.enable(neutral_input_select),
		.start(cmp_pending),
		.value(phase_current_sum),
		.rms(neutral_rms_result)
	);

	// ==========================================================
	// read path
	always_comb begin
		first_status_register_word = '0;
		first_status_register_word[DR_BIT] = data_ready_flag;
		second_status_register_word = '0;
		second_status_register_word[MM_BIT] = mismatch_flag;
		case (reg_addr)
			nc_mismatch_pkg::ADDR_FIRST_STATUS: next_rdata = first_status_register_word;
			nc_mismatch_pkg::ADDR_SECOND_STATUS: next_rdata = second_status_register_word;
			nc_mismatch_pkg::ADDR_SECOND_MASK: next_rdata = second_interrupt_mask;
			nc_mismatch_pkg::ADDR_CONFIG: next_rdata = WORD_W'(neutral_input_select);
			nc_mismatch_pkg::ADDR_PHASE_SUM: next_rdata = {4'h0, phase_current_sum};
			nc_mismatch_pkg::ADDR_THRESHOLD: next_rdata = {4'h0, threshold_ext};
			nc_mismatch_pkg::ADDR_NEUTRAL_RMS: next_rdata = WORD_W'(neutral_rms_result);
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= '0;
			reg_rdata_valid <= 1'b0;
		end else begin
			reg_rdata_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_sum_adds;
		sample_tick |=> phase_current_sum == SUM_W'($past(phase_a_current_sample))
			+ SUM_W'($past(phase_b_current_sample)) + SUM_W'($past(phase_c_current_sample));
	endproperty
	a_sum_adds: assert property (p_sum_adds) else $error("phase sum wrong");

	property p_ready_after_tick;
		sample_tick |-> ##2 data_ready_flag;
	endproperty
	a_ready_after_tick: assert property (p_ready_after_tick) else $error("no data ready");

	property p_tick_alone;
		sample_tick |=> !sample_tick [*8];
	endproperty
	a_tick_alone: assert property (p_tick_alone) else $error("ticks too close");

	property p_mismatch_sets;
		cmp_pending && (abs_diff > threshold_ext) |=> mismatch_flag;
	endproperty
	a_mismatch_sets: assert property (p_mismatch_sets) else $error("mismatch missed");

	property p_no_false_set;
		cmp_pending && threshold_ext > 0 && abs_diff <= threshold_ext && !mismatch_flag
			|=> !mismatch_flag;
	endproperty
	a_no_false_set: assert property (p_no_false_set) else $error("false mismatch");

	property p_zero_threshold;
		cmp_pending && threshold_ext <= 0 |=> mismatch_flag;
	endproperty
	a_zero_threshold: assert property (p_zero_threshold) else $error("threshold not forced");

	property p_clear;
		wr_second_status_register && reg_wdata[MM_BIT] && !cmp_pending |=> !mismatch_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");

	property p_irq_low;
		mismatch_flag && second_interrupt_mask[MM_BIT] |=> !second_interrupt_pin_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("pin not low");

	property p_irq_high;
		!(mismatch_flag && second_interrupt_mask[MM_BIT]) |=> second_interrupt_pin_n;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("pin not high");

	property p_sum_read;
		reg_rd_en && reg_addr == nc_mismatch_pkg::ADDR_PHASE_SUM |=> reg_rdata[WORD_W-1:SUM_W] == 4'h0;
	endproperty
	a_sum_read: assert property (p_sum_read) else $error("sum pad not zero");

	property p_sum_value;
		reg_rd_en && reg_addr == nc_mismatch_pkg::ADDR_PHASE_SUM
			|=> reg_rdata[SUM_W-1:0] == $past(phase_current_sum);
	endproperty
	a_sum_value: assert property (p_sum_value) else $error("sum read wrong");

	property p_thr_read;
		reg_rd_en && reg_addr == nc_mismatch_pkg::ADDR_THRESHOLD
			|=> reg_rdata == {4'h0, $past(threshold_ext)};
	endproperty
	a_thr_read: assert property (p_thr_read) else $error("threshold read wrong");

	property p_neutral_capture;
		sample_tick |=> neutral_hold == SUM_W'($past(neutral_current_sample));
	endproperty
	a_neutral_capture: assert property (p_neutral_capture) else $error("neutral not held");

	property p_ready_clear;
		wr_first_status_register && reg_wdata[DR_BIT] && !cmp_pending |=> !data_ready_flag;
	endproperty
	a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

	property p_irq_release;
		wr_second_status_register && reg_wdata[MM_BIT] && !cmp_pending
			|-> ##2 second_interrupt_pin_n;
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("pin not released");

	c_mismatch: cover property (cmp_pending && exceed && threshold_ext > 0);
	c_clear: cover property (mismatch_flag ##1 !mismatch_flag);
	c_irq: cover property ($fell(second_interrupt_pin_n));
	c_full_scale: cover property (mismatch_threshold == nc_mismatch_pkg::THRESHOLD_FULL_SCALE);
	c_ready_clear: cover property (data_ready_flag ##1 !data_ready_flag);

endmodule

// File: include/nc_mismatch_pkg.sv
// constants shared by the neutral current mismatch block and its rms helper
// assumes a single 40 MHz core clock and a host register port on the same clock
package nc_mismatch_pkg;

	// ==========================================================
	// widths
	localparam int SAMPLE_W = 24;
	localparam int SUM_W = 28;
	localparam int WORD_W = 32;
	localparam int ADDR_W = 16;
	localparam int RMS_W = 24;
	localparam int MS_W = 56;
	localparam int ROOT_W = 28;
	localparam int ROOT_CNT_W = 5;
	localparam int DIV_W = 16;

	// ==========================================================
	// timing
	localparam int CLK_FREQ_HZ = 40000000;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
	localparam int SAMPLE_PERIOD_NS = 125000;
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int RMS_LPF_SHIFT = 8;

	// ==========================================================
	// register indices on the host port
	localparam logic [ADDR_W-1:0] ADDR_FIRST_STATUS = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_SECOND_STATUS = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_SECOND_MASK = 16'h0002;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 16'h0003;
	localparam logic [ADDR_W-1:0] ADDR_PHASE_SUM = 16'h0004;
	localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 16'h0005;
	localparam logic [ADDR_W-1:0] ADDR_NEUTRAL_RMS = 16'h0006;

	// ==========================================================
	// fields and reset values
	localparam int DATA_READY_BIT = 17;
	localparam int MISMATCH_BIT = 20;
	localparam int NEUTRAL_SEL_BIT = 0;
	localparam logic [SAMPLE_W-1:0] THRESHOLD_RESET = 24'h000000;
	localparam logic [SAMPLE_W-1:0] THRESHOLD_FULL_SCALE = 24'h5A7540;
	localparam logic [WORD_W-1:0] MASK_RESET = 32'h00000000;
	localparam logic [RMS_W-1:0] RMS_SATURATE = 24'hFFFFFF;

	// ==========================================================
	// rms root finder states
	typedef enum logic [1:0] {
		RMS_IDLE = 2'b01,
		RMS_ROOT = 2'b10
	} rms_state_e;

endpackage

// File: verilog/sum_rms.sv
// rms estimate of the phase current sum: squared, low-pass filtered, square root
// assumes start pulses arrive far slower than the ROOT_W cycles the root needs
`timescale 1ns/1ps

module sum_rms #(
	parameter int SUM_W = nc_mismatch_pkg::SUM_W,
	parameter int SHIFT = nc_mismatch_pkg::RMS_LPF_SHIFT
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic start,
	input wire logic signed [SUM_W-1:0] value,
	output logic [nc_mismatch_pkg::RMS_W-1:0] rms
);
	localparam int MS_W = nc_mismatch_pkg::MS_W;
	localparam int ROOT_W = nc_mismatch_pkg::ROOT_W;
	localparam int CNT_W = nc_mismatch_pkg::ROOT_CNT_W;

	nc_mismatch_pkg::rms_state_e state;
	logic signed [MS_W-1:0] mean_sq;
	logic [ROOT_W-1:0] root;
	logic [nc_mismatch_pkg::ROOT_CNT_W-1:0] bit_idx;
	logic [SUM_W-1:0] mag;
	logic signed [MS_W-1:0] sq;
	logic signed [MS_W-1:0] next_mean_sq;
	logic [ROOT_W-1:0] trial;
	logic [2*ROOT_W-1:0] trial_sq;

	always_comb begin
		mag = value[SUM_W-1] ? SUM_W'(-value) : SUM_W'(value);
		sq = MS_W'(mag) * MS_W'(mag);
		// first-order filter stands in for the averaging window
		next_mean_sq = mean_sq + ((sq - mean_sq) >>> SHIFT);
		trial = root | (ROOT_W'(1) << bit_idx);
		trial_sq = (2*ROOT_W)'(trial) * (2*ROOT_W)'(trial);
	end

	// ==========================================================
	// filter and root finder
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= nc_mismatch_pkg::RMS_IDLE;
			mean_sq <= '0;
			root <= '0;
			bit_idx <= '0;
			rms <= '0;
		end else begin
			case (state)
				nc_mismatch_pkg::RMS_IDLE: begin
					if (enable && start) begin
						mean_sq <= next_mean_sq;
						root <= '0;
						bit_idx <= CNT_W'(ROOT_W - 1);
						state <= nc_mismatch_pkg::RMS_ROOT;
					end
				end
				nc_mismatch_pkg::RMS_ROOT: begin
					if (trial_sq <= (2*ROOT_W)'(mean_sq)) begin
						root <= trial;
					end
					if (bit_idx == '0) begin
						state <= nc_mismatch_pkg::RMS_IDLE;
						// one bit per cycle keeps the multiplier small
						if ((trial_sq <= (2*ROOT_W)'(mean_sq) ? trial : root)
							> ROOT_W'(nc_mismatch_pkg::RMS_SATURATE)) begin
							rms <= nc_mismatch_pkg::RMS_SATURATE;
						end else begin
							rms <= (trial_sq <= (2*ROOT_W)'(mean_sq)) ?
								trial[nc_mismatch_pkg::RMS_W-1:0] :
								root[nc_mismatch_pkg::RMS_W-1:0];
						end
					end else begin
						bit_idx <= bit_idx - 1'b1;
					end
				end
				default: state <= nc_mismatch_pkg::RMS_IDLE;
			endcase
		end
	end

endmodule

// File: tb/host_model.sv
// host side model: drives the register port of the mismatch block
// assumes single-cycle strobes taken on the rising edge of core_clk
`timescale 1ns/1ps

module host_model (
	input wire logic core_clk,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [nc_mismatch_pkg::ADDR_W-1:0] reg_addr,
	output logic [nc_mismatch_pkg::WORD_W-1:0] reg_wdata,
	input wire logic [nc_mismatch_pkg::WORD_W-1:0] reg_rdata,
	input wire logic reg_rdata_valid
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 32'h00000000;
	end

	// ==========================================================
	// bus cycles
	task automatic wr(input logic [15:0] a, input logic [31:0] dat);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= dat;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		// released data must not keep looking valid
		reg_wdata <= ~dat;
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] dat);
		dat = 'x;
		@(posedge core_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			if (reg_rdata_valid === 1'b1) begin
				dat = reg_rdata;
				break;
			end
		end
	endtask

	// full scale, non-negative, loaded when set_thr is given full scale
	task automatic init_threshold();
		wr(nc_mismatch_pkg::ADDR_THRESHOLD, {8'h00, nc_mismatch_pkg::THRESHOLD_FULL_SCALE});
	endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the neutral current mismatch block
// assumes host_model drives the register port; samples held across ticks
`timescale 1ns/1ps

module tb;
	localparam int SC = 20;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic signed [23:0] pa, pb, pc, pn;
	logic wr_en, rd_en, rvalid, irq_n;
	logic [15:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [23:0] thr = 24'h000000;
	logic msk = 1'b0;
	logic last_mm = 1'b0;
	int ls = 0;
	int ln = 0;
	int fails = 0;
	int samples_checked = 0;

	always #12.5 core_clk = ~core_clk;

	neutral_current_mismatch_detect #(.SAMPLE_CYCLES(SC)) dut (
		.core_clk(core_clk), .nrst(nrst),
		.phase_a_current_sample(pa), .phase_b_current_sample(pb),
		.phase_c_current_sample(pc), .neutral_current_sample(pn),
		.reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata(rdata), .reg_rdata_valid(rvalid), .second_interrupt_pin_n(irq_n)
	);

	host_model host (
		.core_clk(core_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_rdata_valid(rvalid)
	);

	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic logic mm(input int s, input int n, input int t);
		int df;
		df = (s < 0 ? -s : s) - (n < 0 ? -n : n);
		df = df < 0 ? -df : df;
		return (t <= 0) || (df > t);
	endfunction

	task automatic put(input int a, input int b, input int c, input int n);
		@(posedge core_clk);
		pa <= a[23:0];
		pb <= b[23:0];
		pc <= c[23:0];
		pn <= n[23:0];
	endtask

	task automatic set_thr(input logic [23:0] t);
		if (t != nc_mismatch_pkg::THRESHOLD_FULL_SCALE) begin
			host.wr(nc_mismatch_pkg::ADDR_THRESHOLD, {8'h00, t});
		end else begin
			host.init_threshold();
		end
		thr = t;
		host.rd(nc_mismatch_pkg::ADDR_THRESHOLD, d);
		check(d, {4'h0, {4{t[23]}}, t});
		// let old samples meet the new threshold so the sticky flag is predictable
		repeat (SC + 4) @(posedge core_clk);
	endtask

	// two full periods: one to settle, one after the flags are cleared
	task automatic run_case(input int a, input int b, input int c, input int n);
		int s;
		int tt;
		logic e;
		s = a + b + c;
		tt = int'($signed(thr));
		e = mm(s, n, tt);
		put(a, b, c, n);
		repeat (SC + 4) @(posedge core_clk);
		host.rd(nc_mismatch_pkg::ADDR_SECOND_STATUS, d);
		check(d[20], last_mm | e | mm(ls, ln, tt));
		host.wr(nc_mismatch_pkg::ADDR_FIRST_STATUS, 32'h00020000);
		host.wr(nc_mismatch_pkg::ADDR_SECOND_STATUS, 32'h00100000);
		repeat (SC + 4) @(posedge core_clk);
		host.rd(nc_mismatch_pkg::ADDR_FIRST_STATUS, d);
		check(d[17], 1'b1);
		host.rd(nc_mismatch_pkg::ADDR_SECOND_STATUS, d);
		check(d[20], e);
		host.rd(nc_mismatch_pkg::ADDR_PHASE_SUM, d);
		check(d, {4'h0, s[27:0]});
		check(irq_n, !(e && msk));
		last_mm = e;
		ls = s;
		ln = n;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int a;
		int b;
		int c;
		pa = 24'h000000;
		pb = 24'h000000;
		pc = 24'h000000;
		pn = 24'h000000;
		void'($urandom(21814));
		repeat (3) @(posedge core_clk);
		check(irq_n, 1'b1);
		check(rdata, 32'h00000000);
		nrst <= 1'b1;
		host.rd(nc_mismatch_pkg::ADDR_THRESHOLD, d);
		check(d, 32'h00000000);
		host.rd(nc_mismatch_pkg::ADDR_NEUTRAL_RMS, d);
		check(d, 32'h00000000);
		run_case(1000, 2000, -3000, 0);
		msk = 1'b1;
		host.wr(nc_mismatch_pkg::ADDR_SECOND_MASK, 32'h00100000);
		repeat (3) @(posedge core_clk);
		check(irq_n, 1'b0);
		set_thr(nc_mismatch_pkg::THRESHOLD_FULL_SCALE);
		run_case(5928256, 0, 0, 0);
		run_case(5928257, 0, 0, 0);
		run_case(-5928257, 0, 0, 0);
		run_case(-3000000, -3000000, -2000000, 8000000);
		set_thr(24'h800000);
		run_case(1000, 2000, -3000, 0);
		set_thr(24'hFFFFFF);
		run_case(0, 0, 0, 0);
		for (int i = 0; i < 12; i++) begin
			a = int'($urandom_range(0, 4194303)) - 2097152;
			b = int'($urandom_range(0, 4194303)) - 2097152;
			c = int'($urandom_range(0, 4194303)) - 2097152;
			set_thr(24'($urandom_range(0, 1048575)));
			run_case(a, b, c, a + b + c + int'($urandom_range(0, 2097151)) - 1048576);
		end
		host.wr(16'h0040, 32'hFFFFFFFF);
		host.rd(16'h0040, d);
		check(d, 32'h00000000);
		host.wr(nc_mismatch_pkg::ADDR_CONFIG, 32'h00000001);
		put(2000000, 2000000, 2000000, 6000000);
		repeat (30 * SC) @(posedge core_clk);
		host.rd(nc_mismatch_pkg::ADDR_NEUTRAL_RMS, d);
		check(d != 32'h00000000, 1'b1);
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		check(irq_n, 1'b1);
		nrst <= 1'b1;
		host.rd(nc_mismatch_pkg::ADDR_THRESHOLD, d);
		check(d, 32'h00000000);
		tally_and_finish();
	end

	// ==========================================================
	// watchdog, well past the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		tally_and_finish();
	end
endmodule
